// File: hw/fmbs_pkg.sv
// Purpose: Shared constants for the flash mode and block select control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register indices are kept as printed; byte address is four times the index
package fmbs_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register indices and byte addresses
   localparam logic [15:0] FMBS_IDX_MODE_CTRL = 16'hfee0;
   localparam logic [15:0] FMBS_IDX_LARGE_SEL = 16'hfee2;
   localparam logic [15:0] FMBS_IDX_SMALL_SEL = 16'hfee3;
   localparam logic [15:0] FMBS_IDX_SUPPLY_STAT = 16'hfee4;
   localparam int FMBS_ADDR_W = 18;
   localparam logic [17:0] FMBS_ADDR_MODE_CTRL = {FMBS_IDX_MODE_CTRL, 2'b00};
   localparam logic [17:0] FMBS_ADDR_LARGE_SEL = {FMBS_IDX_LARGE_SEL, 2'b00};
   localparam logic [17:0] FMBS_ADDR_SMALL_SEL = {FMBS_IDX_SMALL_SEL, 2'b00};
   localparam logic [17:0] FMBS_ADDR_SUPPLY_STAT = {FMBS_IDX_SUPPLY_STAT, 2'b00};

   ////////////////////////////////////////////////////////////////////////////////
   // Control and status register fields
   localparam int FMBS_BIT_VPP_DET = 7;
   localparam int FMBS_BIT_SUPPLY_EN = 6;
   localparam int FMBS_BIT_ERASE_VERIFY = 3;
   localparam int FMBS_BIT_PROG_VERIFY = 2;
   localparam int FMBS_BIT_ERASE = 1;
   localparam int FMBS_BIT_PROGRAM = 0;
   localparam int FMBS_BIT_SETTLED = 0;
   localparam logic [7:0] FMBS_RESET_VAL = 8'h00;
   localparam logic [3:0] FMBS_MODE_RESET = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // Block map: seven 16 kbyte and one 12 kbyte large blocks, eight 512 byte small blocks
   localparam int FMBS_NUM_BLK = 8;
   localparam int FMBS_LARGE_KB = 16;
   localparam int FMBS_SHORT_LARGE_KB = 12;
   localparam int FMBS_SMALL_BYTES = 512;
   localparam logic [17:0] FMBS_PAGE1_BASE = 18'h10000;
   localparam logic [17:0] FMBS_SHORT_LARGE_END = 18'h13000 - 18'h1;
   localparam logic [17:0] FMBS_SMALL_END = FMBS_PAGE1_BASE + 18'h3fff;
   localparam logic [17:0] FMBS_FLASH_END = 18'h2ffff;
   localparam logic [3:0] FMBS_LB0_SLOT = 4'hb;

   ////////////////////////////////////////////////////////////////////////////////
   // Supply settle time
   localparam int FMBS_CLK_PERIOD_NS = 4;
   localparam int FMBS_SETTLE_NS = 5000;
   localparam int FMBS_SETTLE_CYC = (FMBS_SETTLE_NS + FMBS_CLK_PERIOD_NS - 1) / FMBS_CLK_PERIOD_NS;
   localparam int FMBS_CNT_W = 11;

endpackage : fmbs_pkg

// File: hw/fmbs_blk_map.sv
// Purpose: Maps a flash byte offset onto its large or small erase block
// Assumes: 18-bit offset; page 0 low 16 kbytes alias the page 1 window
// Notes:   Offsets outside the flash array report no hit
`timescale 1ns/1ns
`default_nettype none
module fmbs_blk_map
   import fmbs_pkg::*;
(
   input wire logic [17:0] addr_i,
   input wire logic [7:0] large_sel_i,
   input wire logic [7:0] small_sel_i,
   output logic is_large_o,
   output logic is_small_o,
   output logic [2:0] blk_idx_o,
   output logic hit_sel_o
);

   logic [17:0] norm_addr;
   logic in_short_large;
   logic in_small;
   logic in_large;
   logic [3:0] slot_diff;

   // Page 0 mapping area is the same memory as the page 1 copy
   assign norm_addr = (addr_i[17:14] == 4'h0) ? (addr_i | FMBS_PAGE1_BASE) : addr_i;
   assign in_short_large = (norm_addr >= FMBS_PAGE1_BASE) && (norm_addr <= FMBS_SHORT_LARGE_END);
   assign in_small = (norm_addr > FMBS_SHORT_LARGE_END) && (norm_addr <= FMBS_SMALL_END);
   assign in_large = (norm_addr > FMBS_SMALL_END) && (norm_addr <= FMBS_FLASH_END);
   assign slot_diff = FMBS_LB0_SLOT - norm_addr[17:14];

   assign is_large_o = in_short_large | in_large;
   assign is_small_o = in_small;
   assign blk_idx_o = in_short_large ? 3'h7 : (in_small ? norm_addr[11:9] : slot_diff[2:0]);
   assign hit_sel_o = (is_large_o & large_sel_i[blk_idx_o]) | (is_small_o & small_sel_i[blk_idx_o]);

endmodule // fmbs_blk_map
`default_nettype wire

// File: hw/fmbs_ctrl.sv
// Purpose: Flash mode control and erase/program block select registers on APB
// Assumes: Voltage detect and standby inputs are synchronous to CLK_I
// Notes:   Zero wait state slave; unmapped addresses answer with PSLVERR
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module fmbs_ctrl
   import fmbs_pkg::*;
#(
   parameter int SETTLE_CYC = FMBS_SETTLE_CYC
)
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic VPP_DETECT_I,
   input wire logic STANDBY_I,
   input wire logic [17:0] FLASH_ADDR_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [31:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic PROG_SUPPLY_EN_O,
   output logic PROGRAM_MODE_O,
   output logic ERASE_MODE_O,
   output logic PROG_VERIFY_O,
   output logic ERASE_VERIFY_O,
   output logic SUPPLY_SETTLED_O,
   output logic [7:0] LARGE_BLK_SEL_O,
   output logic [7:0] SMALL_BLK_SEL_O,
   output logic ADDR_IN_SEL_BLK_O
);

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic logic addr_is(input logic [31:0] a, input logic [17:0] reg_addr);
      addr_is = (a[31:FMBS_ADDR_W] == '0) && (a[FMBS_ADDR_W-1:0] == reg_addr);
   endfunction

   logic sel_ctrl;
   logic sel_large;
   logic sel_small;
   logic sel_stat;
   logic mapped;
   logic wr_access;
   logic wr_lane0;

   assign sel_ctrl = addr_is(PADDR_I, FMBS_ADDR_MODE_CTRL);
   assign sel_large = addr_is(PADDR_I, FMBS_ADDR_LARGE_SEL);
   assign sel_small = addr_is(PADDR_I, FMBS_ADDR_SMALL_SEL);
   assign sel_stat = addr_is(PADDR_I, FMBS_ADDR_SUPPLY_STAT);
   assign mapped = sel_ctrl | sel_large | sel_small | sel_stat;
   assign wr_access = PSEL_I & PENABLE_I & PWRITE_I & mapped;
   // Registers are eight bits wide, so only byte lane 0 carries data
   assign wr_lane0 = wr_access & PSTRB_I[0];

   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

   ////////////////////////////////////////////////////////////////////////////////
   // Clearing conditions
   logic clear_all;

   // Standby and loss of programming voltage act like reset on every register except the read data, which only RESET_I clears
   assign clear_all = RESET_I | STANDBY_I | ~VPP_DETECT_I;

   ////////////////////////////////////////////////////////////////////////////////
   // Control and block select registers
   logic supply_en_reg;
   logic supply_en_next;
   logic [3:0] mode_reg;
   logic [3:0] mode_next;
   logic [7:0] large_sel_reg;
   logic [7:0] large_sel_next;
   logic [7:0] small_sel_reg;
   logic [7:0] small_sel_next;
   logic [3:0] mode_gate;
   logic [7:0] blk_gate;

   // Gate uses the stored enable, so a write setting both at once cannot slip a mode in
   assign mode_gate = {4{supply_en_reg}};
   assign blk_gate = {8{supply_en_reg}};

   assign supply_en_next = (wr_lane0 & sel_ctrl) ? PWDATA_I[FMBS_BIT_SUPPLY_EN] : supply_en_reg;
   // Bits 5 and 4 are never stored
   assign mode_next = (wr_lane0 & sel_ctrl) ? (PWDATA_I[3:0] & mode_gate) : mode_reg;
   assign large_sel_next = (wr_lane0 & sel_large) ? (PWDATA_I[7:0] & blk_gate) : large_sel_reg;
   assign small_sel_next = (wr_lane0 & sel_small) ? (PWDATA_I[7:0] & blk_gate) : small_sel_reg;

   always_ff @(posedge CLK_I) begin
      if (clear_all) begin
         supply_en_reg <= 1'b0;
         mode_reg <= FMBS_MODE_RESET;
      end else begin
         supply_en_reg <= supply_en_next;
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (clear_all) begin
         large_sel_reg <= FMBS_RESET_VAL;
         small_sel_reg <= FMBS_RESET_VAL;
      end else begin
         large_sel_reg <= large_sel_next;
         small_sel_reg <= small_sel_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Supply settle timer
   logic [FMBS_CNT_W-1:0] settle_cnt_reg;
   logic [FMBS_CNT_W-1:0] settle_cnt_next;
   logic settled;
   localparam logic [FMBS_CNT_W-1:0] SETTLE_LAST = FMBS_CNT_W'(SETTLE_CYC);

   // Status only; the hardware does not block software that ignores it
   assign settled = (settle_cnt_reg == SETTLE_LAST);
   assign settle_cnt_next = (!supply_en_reg) ? '0 : (settled ? settle_cnt_reg : settle_cnt_reg + 1'b1);

   always_ff @(posedge CLK_I) begin
      if (clear_all) begin
         settle_cnt_reg <= '0;
      end else begin
         settle_cnt_reg <= settle_cnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data
   logic [7:0] ctrl_view;
   logic [7:0] rd_byte;

   // Bit 7 follows the detect input live, which gives 0x80 after reset with voltage on
   assign ctrl_view = {VPP_DETECT_I, supply_en_reg, 2'b00, mode_reg};
   assign rd_byte = sel_ctrl ? ctrl_view :
                    sel_large ? large_sel_reg :
                    sel_small ? small_sel_reg :
                    sel_stat ? {7'h00, settled} : 8'h00;

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
         PRDATA_O <= {24'h00_0000, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs to the flash array
   assign PROG_SUPPLY_EN_O = supply_en_reg;
   assign ERASE_VERIFY_O = mode_reg[FMBS_BIT_ERASE_VERIFY];
   assign PROG_VERIFY_O = mode_reg[FMBS_BIT_PROG_VERIFY];
   assign ERASE_MODE_O = mode_reg[FMBS_BIT_ERASE];
   assign PROGRAM_MODE_O = mode_reg[FMBS_BIT_PROGRAM];
   assign SUPPLY_SETTLED_O = settled;
   assign LARGE_BLK_SEL_O = large_sel_reg;
   assign SMALL_BLK_SEL_O = small_sel_reg;

   fmbs_blk_map u_blk_map (
      .addr_i(FLASH_ADDR_I),
      .large_sel_i(large_sel_reg),
      .small_sel_i(small_sel_reg),
      .is_large_o(),
      .is_small_o(),
      .blk_idx_o(),
      .hit_sel_o(ADDR_IN_SEL_BLK_O)
   );

endmodule // fmbs_ctrl
`default_nettype wire

// File: verif/fmbs_ctrl_asserts.sv
// Purpose: Port assertions for the flash mode control block
// Assumes: Zero wait APB, read data captured in the setup cycle
// Notes:   Sees top ports only
`timescale 1ns/1ns
`default_nettype none
module fmbs_ctrl_asserts
   import fmbs_pkg::*;
#(
   parameter int SETTLE_CYC = 8
)
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic VPP_DETECT_I,
   input wire logic STANDBY_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [31:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PROG_SUPPLY_EN_O,
   input wire logic PROGRAM_MODE_O,
   input wire logic ERASE_MODE_O,
   input wire logic PROG_VERIFY_O,
   input wire logic ERASE_VERIFY_O,
   input wire logic [7:0] LARGE_BLK_SEL_O,
   input wire logic [7:0] SMALL_BLK_SEL_O
);
   // Writes only count when no clear condition holds at the same edge
   wire logic wok = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && VPP_DETECT_I && !STANDBY_I;
   wire logic [3:0] mode = {ERASE_VERIFY_O, PROG_VERIFY_O, ERASE_MODE_O, PROGRAM_MODE_O};
   wire logic [7:0] wd = PWDATA_I[7:0];
   wire logic clr = STANDBY_I || !VPP_DETECT_I;
   wire logic rd_ctrl = PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == {14'h0, FMBS_ADDR_MODE_CTRL};
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   ////////////////////////////////////////////////////////////////////////////////
   chk_ctrl_clear: assert property (clr |=> !PROG_SUPPLY_EN_O && mode == 4'h0)
      else $error("control not cleared");
   chk_sel_clear: assert property (clr |=> LARGE_BLK_SEL_O == 8'h00 && SMALL_BLK_SEL_O == 8'h00)
      else $error("block select not cleared");
   chk_mode_gate: assert property ((mode & ~$past(mode)) != 4'h0 |-> $past(PROG_SUPPLY_EN_O))
      else $error("mode bit set without supply");
   chk_blk_gate: assert property (((LARGE_BLK_SEL_O & ~$past(LARGE_BLK_SEL_O)) |
      (SMALL_BLK_SEL_O & ~$past(SMALL_BLK_SEL_O))) != 8'h00 |-> $past(PROG_SUPPLY_EN_O))
      else $error("block bit set without supply");
   chk_ctrl_read: assert property (rd_ctrl |-> PRDATA_O[31:8] == 24'h0 && PRDATA_O[6:0] ==
      {$past(PROG_SUPPLY_EN_O), 2'b00, $past(mode)}) else $error("control read wrong");
   chk_vpp_read: assert property (rd_ctrl |-> PRDATA_O[7] == $past(VPP_DETECT_I))
      else $error("voltage bit wrong");
   chk_mode_write: assert property (wok && PROG_SUPPLY_EN_O && PADDR_I == {14'h0, FMBS_ADDR_MODE_CTRL}
      |=> mode == $past(wd[3:0]) && PROG_SUPPLY_EN_O == $past(wd[6])) else $error("mode write lost");
   chk_large_write: assert property (wok && PROG_SUPPLY_EN_O && PADDR_I == {14'h0, FMBS_ADDR_LARGE_SEL}
      |=> LARGE_BLK_SEL_O == $past(wd)) else $error("large select write lost");
   chk_small_write: assert property (wok && PROG_SUPPLY_EN_O && PADDR_I == {14'h0, FMBS_ADDR_SMALL_SEL}
      |=> SMALL_BLK_SEL_O == $past(wd)) else $error("small select write lost");
endmodule // fmbs_ctrl_asserts
bind fmbs_ctrl fmbs_ctrl_asserts #(.SETTLE_CYC(SETTLE_CYC)) fmbs_ctrl_asserts_i (.CLK_I(CLK_I), .RESET_I(RESET_I),
   .VPP_DETECT_I(VPP_DETECT_I), .STANDBY_I(STANDBY_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PROG_SUPPLY_EN_O(PROG_SUPPLY_EN_O),
   .PROGRAM_MODE_O(PROGRAM_MODE_O), .ERASE_MODE_O(ERASE_MODE_O), .PROG_VERIFY_O(PROG_VERIFY_O),
   .ERASE_VERIFY_O(ERASE_VERIFY_O), .LARGE_BLK_SEL_O(LARGE_BLK_SEL_O), .SMALL_BLK_SEL_O(SMALL_BLK_SEL_O));
`default_nettype wire

// File: verif/fmbs_ctrl_test.sv
// Purpose: Self-checking bench for the flash mode control block
// Assumes: Short settle count, APB master in this module
// Notes:   Random select values come from an 8-bit LFSR
`timescale 1ns/1ns
`default_nettype none
module fmbs_ctrl_test
   import fmbs_pkg::*;
;
   logic clk = 0, rst = 1, vpp = 1, stby = 0, psel = 0, pen = 0, pwr = 0;
   logic [17:0] fa = 18'h0;
   logic [31:0] pa = 32'h0, pwd = 32'h0, d;
   logic [3:0] ps = 4'h0;
   logic [7:0] r = 8'h15;
   logic e;
   wire logic [31:0] prd;
   wire logic prdy, perr, sup, pm, em, pv, ev, hit, stl;
   wire logic [7:0] lsel, ssel;
   int n_mismatch = 0, checks_done = 0, i;
   // Page 0 offset 03000 aliases small block 0; 30000 lies past the array
   logic [17:0] fav [8] = '{18'h14000, 18'h2c000, 18'h18000, 18'h13000, 18'h13200, 18'h10000, 18'h03000,
      18'h30000};
   logic hv [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   fmbs_ctrl #(.SETTLE_CYC(8)) fmbs_ctrl_i (.CLK_I(clk), .RESET_I(rst), .VPP_DETECT_I(vpp), .STANDBY_I(stby),
      .FLASH_ADDR_I(fa), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
      .PSTRB_I(ps), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .PROG_SUPPLY_EN_O(sup),
      .PROGRAM_MODE_O(pm), .ERASE_MODE_O(em), .PROG_VERIFY_O(pv), .ERASE_VERIFY_O(ev), .SUPPLY_SETTLED_O(stl),
      .LARGE_BLK_SEL_O(lsel), .SMALL_BLK_SEL_O(ssel), .ADDR_IN_SEL_BLK_O(hit));
   initial begin
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic [31:0] ctrl_exp(input logic v, input logic s, input logic [3:0] m);
      return {24'h0, v, s, 2'b00, m};
   endfunction
   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      cmp_data({31'h0, got}, {31'h0, exp});
   endtask
   // Request held until pready is seen high; data taken at that edge
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      pa <= {14'h0, a};
      pwd <= {24'h0, wd};
      ps <= w ? 4'hf : 4'h0;
      @(posedge clk);
      pen <= 1;
      // Only the watchdog may end a wait for pready
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      d = prd;
      e = perr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] exp);
      apb(0, a, 8'h00);
      cmp_data(d, exp);
   endtask
   task automatic end_test(input string n);
      $display("Test %s finished", n);
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      finish_test;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      rd(FMBS_ADDR_MODE_CTRL, 32'h80);
      rd(FMBS_ADDR_LARGE_SEL, 32'h0);
      rd(FMBS_ADDR_SMALL_SEL, 32'h0);
      apb(1, FMBS_ADDR_MODE_CTRL, 8'h01);
      rd(FMBS_ADDR_MODE_CTRL, 32'h80);
      apb(1, FMBS_ADDR_LARGE_SEL, 8'hff);
      rd(FMBS_ADDR_LARGE_SEL, 32'h0);
      apb(1, FMBS_ADDR_MODE_CTRL, 8'h70);
      cmp_flag(stl, 1'b0);
      rd(FMBS_ADDR_MODE_CTRL, ctrl_exp(1, 1, 4'h0));
      rd(FMBS_ADDR_SUPPLY_STAT, 32'h0);
      // Software lets the supply settle before any mode change
      repeat (8) @(posedge clk);
      rd(FMBS_ADDR_SUPPLY_STAT, 32'h1);
      cmp_flag(stl, 1'b1);
      end_test("gating");
      // One mode bit per write, supply left on in between
      for (i = 0; i < 4; i++) begin
         apb(1, FMBS_ADDR_MODE_CTRL, 8'h40 | (8'h01 << i));
         // Register outputs move only after the storing edge has settled
         @(negedge clk);
         cmp_data({28'h0, ev, pv, em, pm}, 32'h1 << i);
         rd(FMBS_ADDR_MODE_CTRL, ctrl_exp(1, 1, 4'h1 << i));
         apb(1, FMBS_ADDR_MODE_CTRL, 8'h40);
      end
      for (i = 0; i < 6; i++) begin
         r = lfsr(r);
         apb(1, FMBS_ADDR_LARGE_SEL, r);
         rd(FMBS_ADDR_LARGE_SEL, {24'h0, r});
         r = lfsr(r);
         apb(1, FMBS_ADDR_SMALL_SEL, r);
         @(negedge clk);
         cmp_data({24'h0, ssel}, {24'h0, r});
      end
      apb(1, FMBS_ADDR_LARGE_SEL, 8'h41);
      apb(1, FMBS_ADDR_SMALL_SEL, 8'h01);
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         fa <= fav[i];
         @(posedge clk);
         cmp_flag(hit, hv[i]);
      end
      // Mode bits are already clear, so the supply may now be dropped
      apb(1, FMBS_ADDR_MODE_CTRL, 8'h00);
      rd(FMBS_ADDR_MODE_CTRL, 32'h80);
      cmp_flag(stl, 1'b0);
      apb(0, 18'h3fb84, 8'h00);
      cmp_flag(e, 1'b1);
      cmp_data(d, 32'h0);
      end_test("modes and selects");
      @(posedge clk);
      stby <= 1;
      @(posedge clk);
      stby <= 0;
      rd(FMBS_ADDR_MODE_CTRL, 32'h80);
      rd(FMBS_ADDR_LARGE_SEL, 32'h0);
      rd(FMBS_ADDR_SMALL_SEL, 32'h0);
      apb(1, FMBS_ADDR_MODE_CTRL, 8'h40);
      apb(1, FMBS_ADDR_SMALL_SEL, 8'h0f);
      @(posedge clk);
      vpp <= 0;
      rd(FMBS_ADDR_MODE_CTRL, 32'h0);
      rd(FMBS_ADDR_SMALL_SEL, 32'h0);
      @(posedge clk);
      vpp <= 1;
      apb(1, FMBS_ADDR_MODE_CTRL, 8'h40);
      apb(1, FMBS_ADDR_MODE_CTRL, 8'h42);
      @(posedge clk);
      rst <= 1;
      @(posedge clk);
      rst <= 0;
      rd(FMBS_ADDR_MODE_CTRL, 32'h80);
      end_test("clears");
      finish_test;
   end
endmodule // fmbs_ctrl_test
`default_nettype wire
